// ---- verilog/bsm_monitor.sv ----
// Supply switchover monitor with timestamps, brownout and battery flags
module bsm_monitor
	import bsm_pkg::*;
#(
	parameter int TICK_DIV = BSM_TICK_DIV,
	parameter int TW = 32
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Analog comparator results (asynchronous)
	input wire logic cmp_below_backup,
	input wire logic cmp_above_backup,
	input wire logic cmp_below_trip,
	input wire logic cmp_above_trip_hys,
	input wire logic [5:0] cmp_brownout,
	input wire logic cmp_batt_below85,
	input wire logic cmp_batt_below75,
	input wire logic total_loss_seen,
	// Live time and date from the calendar
	input wire logic [TW-1:0] cur_time,
	// Mode and gating outputs
	output logic backup_mode,
	output logic serial_if_enable,
	output logic temp_sense_run,
	output logic batt_measure,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ==========================================================
	// Elaboration checks
	if (TW < 1 || TW > 32) $error("TW must be 1..32");

	// ==========================================================
	// Timebase and synchronisers; the timebase never stops in backup
	logic tick;
	logic [12:0] cmp_s;
	bsm_tick #(.DIV(TICK_DIV)) u_tick (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.tick(tick)
	);
	// Comparators pass two flops before any logic reads them
	bsm_sync2 #(.W(13)) u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.d({total_loss_seen, cmp_batt_below75, cmp_batt_below85, cmp_brownout,
			cmp_above_trip_hys, cmp_below_trip, cmp_above_backup, cmp_below_backup}),
		.q(cmp_s)
	);
	logic below_bak, above_bak, below_trip, above_trip, b85, b75, loss_s;
	logic [5:0] brn_s;
	assign below_bak = cmp_s[0];
	assign above_bak = cmp_s[1];
	assign below_trip = cmp_s[2];
	assign above_trip = cmp_s[3];
	assign brn_s = cmp_s[9:4];
	assign b85 = cmp_s[10];
	assign b75 = cmp_s[11];
	assign loss_s = cmp_s[12];

	// ==========================================================
	// Registers
	bsm_mode_t mode_q;
	logic [TW-1:0] v2b_q, b2v_q;
	logic v2b_full_q;
	logic tse_q, backup_temp_sense_enable_q;
	logic [BSM_TRIP_W-1:0] trip_q;
	logic tpf_q, brn_q, lb1_q, lb2_q;
	logic meas_req_q;
	logic wr_go, clr_go, tse_go;
	logic [31:0] wd;

	// Mode transitions happen only on timebase ticks
	logic go_backup, go_main;
	assign go_backup = tick && mode_q == BSM_MAIN && below_bak && below_trip;
	assign go_main = tick && mode_q == BSM_BACKUP && (above_bak || above_trip);

	// Supply mode state machine
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			mode_q <= BSM_MAIN;
		else
		begin
			case (mode_q)
				BSM_MAIN: if (go_backup) mode_q <= BSM_BACKUP;
				BSM_BACKUP: if (go_main) mode_q <= BSM_MAIN;
				default: mode_q <= BSM_MAIN;
			endcase
		end
	end

	// Entry stamp: first entry kept until clear; capture beats clear
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			v2b_q <= '0;
			v2b_full_q <= 1'b0;
		end
		else if (go_backup && (!v2b_full_q || clr_go))
		begin
			v2b_q <= cur_time;
			v2b_full_q <= 1'b1;
		end
		else if (clr_go)
		begin
			v2b_q <= '0;
			v2b_full_q <= 1'b0;
		end
	end

	// Return stamp: always the most recent return
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			b2v_q <= '0;
		else if (go_main)
			b2v_q <= cur_time;
		else if (clr_go)
			b2v_q <= '0;
	end

	// Control bits; the host cannot write while in backup
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tse_q <= 1'b0;
			backup_temp_sense_enable_q <= 1'b0;
			trip_q <= BSM_TRIP_RST;
		end
		else if (wr_go)
		begin
			tse_q <= wd[BSM_TSE_BIT];
			backup_temp_sense_enable_q <= wd[BSM_BACKUP_TEMP_SENSE_ENABLE_BIT];
			// Out-of-range level codes are clamped to the highest level
			trip_q <= (wd[BSM_TRIP_LSB +: BSM_TRIP_W] > BSM_TRIP_MAX) ? BSM_TRIP_MAX
				: wd[BSM_TRIP_LSB +: BSM_TRIP_W];
		end
	end

	// Brownout flag: set on selected level, cleared on a tick in main mode once that level is gone
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			brn_q <= 1'b0;
		else if (tick && brn_s[trip_q])
			brn_q <= 1'b1;
		else if (tick && !brn_s[trip_q] && mode_q == BSM_MAIN)
			brn_q <= 1'b0;
	end

	// Total power fail flag caught after reset release, cleared by clear bit
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			tpf_q <= 1'b0;
		else if (tick && loss_s)
			tpf_q <= 1'b1;
		else if (clr_go)
			tpf_q <= 1'b0;
	end

	// Battery measurement on enable write; frozen in backup
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meas_req_q <= 1'b0;
			lb1_q <= 1'b0;
			lb2_q <= 1'b0;
		end
		else
		begin
			if (tse_go)
				meas_req_q <= 1'b1;
			else if (tick && mode_q == BSM_MAIN)
				meas_req_q <= 1'b0;
			if (meas_req_q && tick && mode_q == BSM_MAIN)
			begin
				lb1_q <= b85 || b75;
				lb2_q <= b75;
			end
		end
	end

	// ==========================================================
	// Outputs, all registered
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			backup_mode <= 1'b0;
			serial_if_enable <= 1'b1;
			temp_sense_run <= 1'b0;
			batt_measure <= 1'b0;
		end
		else
		begin
			backup_mode <= (mode_q == BSM_BACKUP);
			// Only the mode gates the interface, brownout does not
			serial_if_enable <= (mode_q == BSM_MAIN);
			temp_sense_run <= tse_q && (mode_q == BSM_MAIN || backup_temp_sense_enable_q);
			batt_measure <= meas_req_q;
		end
	end

	// ==========================================================
	// AXI4-Lite write path: either order; gated by the live mode so no access slips into backup
	logic aw_q, w_q, ws0_q;
	logic [7:0] awa_q;
	logic [31:0] wd_q;
	assign wd = wd_q;
	assign wr_go = aw_q && w_q && !s_axi_bvalid && ws0_q && mode_q == BSM_MAIN && (awa_q == BSM_CTRL_OFS);
	assign clr_go = wr_go && wd[BSM_CLR_BIT];
	assign tse_go = wr_go && wd[BSM_TSE_BIT];
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h00000000;
			ws0_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= BSM_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q <= 1'b1;
				awa_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws0_q <= s_axi_wstrb[0];
			end
			if (aw_q && w_q && !s_axi_bvalid)
			begin
				s_axi_bvalid <= 1'b1;
				// Host access refused while on backup supply
				s_axi_bresp <= (mode_q != BSM_MAIN || awa_q != BSM_CTRL_OFS) ? BSM_RESP_SLVERR
					: BSM_RESP_OKAY;
				aw_q <= 1'b0;
				w_q <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	logic [31:0] rmux;
	always_comb
	begin
		rmux = 32'h00000000;
		case (s_axi_araddr)
			BSM_CTRL_OFS: rmux = {25'h0, trip_q, 1'b0, backup_temp_sense_enable_q, tse_q, 1'b0};
			BSM_STATUS_OFS: rmux = {25'h0, serial_if_enable, temp_sense_run,
				mode_q == BSM_BACKUP, brn_q, lb1_q, lb2_q, tpf_q};
			BSM_TIME_OFS: rmux = 32'(cur_time);
			BSM_V2B_OFS: rmux = 32'(v2b_q);
			BSM_B2V_OFS: rmux = 32'(b2v_q);
			default: rmux = 32'h00000000;
		endcase
	end
	logic rd_ok;
	assign rd_ok = (s_axi_araddr == BSM_CTRL_OFS) || (s_axi_araddr == BSM_STATUS_OFS)
		|| (s_axi_araddr == BSM_TIME_OFS) || (s_axi_araddr == BSM_V2B_OFS) || (s_axi_araddr == BSM_B2V_OFS);
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= BSM_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= (mode_q == BSM_MAIN && rd_ok) ? rmux : 32'h00000000;
				s_axi_rresp <= (mode_q == BSM_MAIN && rd_ok) ? BSM_RESP_OKAY : BSM_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // bsm_monitor

// ---- inc/bsm_pkg.sv ----
// Package of constants for the battery switchover monitor
package bsm_pkg;
	// ==========================================================
	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] BSM_CTRL_OFS = 8'h00;
	localparam logic [7:0] BSM_STATUS_OFS = 8'h04;
	localparam logic [7:0] BSM_TIME_OFS = 8'h08;
	localparam logic [7:0] BSM_V2B_OFS = 8'h0C;
	localparam logic [7:0] BSM_B2V_OFS = 8'h10;
	// ==========================================================
	// Control register fields
	localparam int BSM_CLR_BIT = 0;
	localparam int BSM_TSE_BIT = 1;
	localparam int BSM_BACKUP_TEMP_SENSE_ENABLE_BIT = 2;
	localparam int BSM_TRIP_LSB = 4;
	localparam int BSM_TRIP_W = 3;
	localparam logic [2:0] BSM_TRIP_MAX = 3'h5;
	localparam logic [2:0] BSM_TRIP_RST = 3'h0;
	// ==========================================================
	// Status register fields
	localparam int BSM_ST_TPF = 0;
	localparam int BSM_ST_LB2 = 1;
	localparam int BSM_ST_LB1 = 2;
	localparam int BSM_ST_BRN = 3;
	localparam int BSM_ST_BKP = 4;
	localparam int BSM_ST_TEMP = 5;
	localparam int BSM_ST_IFEN = 6;
	// ==========================================================
	// Timebase: 32.768 kHz tick derived from the 100 MHz clock
	localparam int BSM_CLK_HZ = 100000000;
	localparam int BSM_TICK_HZ = 32768;
	localparam int BSM_TICK_DIV = BSM_CLK_HZ / BSM_TICK_HZ;
	// AXI responses
	localparam logic [1:0] BSM_RESP_OKAY = 2'h0;
	localparam logic [1:0] BSM_RESP_SLVERR = 2'h2;
	// Mode state
	typedef enum logic [0:0] {BSM_MAIN = 1'b0, BSM_BACKUP = 1'b1} bsm_mode_t;
endpackage

// ---- verilog/bsm_sync2.sv ----
// Two flip-flop synchroniser for a bus of asynchronous levels
module bsm_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// ==========================================================
	// Storage
	if (W < 1) $error("W must be at least 1");
	logic [W-1:0] meta_q;
	// First stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // bsm_sync2

// ---- verilog/bsm_tick.sv ----
// Divider that makes the one-cycle timebase enable pulse
module bsm_tick #(
	parameter int DIV = 3051
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Enable pulse
	output logic tick
);
	// ==========================================================
	// Counter
	if (DIV < 2 || DIV > 65536) $error("DIV must be 2..65536");
	logic [15:0] cnt_q;
	localparam logic [15:0] LAST = 16'(DIV - 1);
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 16'h0000;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (cnt_q == LAST);
			cnt_q <= (cnt_q == LAST) ? 16'h0000 : cnt_q + 16'h0001;
		end
	end
endmodule // bsm_tick

// ---- sim/bsm_monitor_asserts.sv ----
// Port checker for the battery switchover monitor
module bsm_monitor_asserts
	import bsm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Supply comparators
	input wire logic cmp_below_backup,
	input wire logic cmp_above_backup,
	input wire logic cmp_below_trip,
	input wire logic cmp_above_trip_hys,
	// Mode outputs
	input wire logic backup_mode,
	input wire logic serial_if_enable,
	input wire logic batt_measure,
	// Bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// ==========================================================
	// Two sync flops, the tick edge and the output flop put the cause four edges back
	enter_both_a: assert property ($rose(backup_mode)
		|-> $past(cmp_below_backup, 4) && $past(cmp_below_trip, 4))
		else $error("backup entered without both low conditions");
	leave_either_a: assert property ($fell(backup_mode)
		|-> $past(cmp_above_backup, 4) || $past(cmp_above_trip_hys, 4))
		else $error("main resumed without a high condition");
	// A comparator value younger than the synchronisers cannot move the mode
	sync_delay_a: assert property (!backup_mode && !$past(cmp_below_backup, 3) |=> !backup_mode)
		else $error("mode changed on an unsynchronised comparator");
	// ==========================================================
	// Gating of the host side
	serial_off_a: assert property (backup_mode && $past(backup_mode) |-> !serial_if_enable)
		else $error("serial interface on in backup");
	serial_on_a: assert property (!backup_mode && !$past(backup_mode) |-> serial_if_enable)
		else $error("serial interface off in main");
	no_measure_a: assert property ($rose(batt_measure) |-> !$past(backup_mode))
		else $error("battery measurement started in backup");
	read_refused_a: assert property ($rose(s_axi_rvalid) && backup_mode |-> s_axi_rresp == BSM_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("read served in backup");
	write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
endmodule // bsm_monitor_asserts

bind bsm_monitor bsm_monitor_asserts i_chk (.ref_clk(ref_clk), .arst_n(arst_n),
	.cmp_below_backup(cmp_below_backup), .cmp_above_backup(cmp_above_backup), .cmp_below_trip(cmp_below_trip),
	.cmp_above_trip_hys(cmp_above_trip_hys), .backup_mode(backup_mode), .serial_if_enable(serial_if_enable),
	.batt_measure(batt_measure), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata));

// ---- sim/bsm_host_model.sv ----
// Host model: AXI4-Lite master that reads status and writes control
module bsm_host_model
(
	// Clock
	input wire logic ref_clk,
	// Write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
	// ==========================================================
	// Address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		@(posedge ref_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		resp = bresp;
	endtask
	// Read waits for the answer however long it takes
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		resp = rresp;
	endtask
endmodule // bsm_host_model

// ---- sim/test_battery_switchover_monitor.sv ----
// Self-checking bench for the battery switchover monitor
module test_battery_switchover_monitor
	import bsm_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic bb, ab, bt, at, b85, b75, tls, bm, sie, tsr, bms;
	logic [5:0] brn;
	logic [31:0] cur_time, d;
	logic [1:0] r;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;
	wire [7:0] awa, ara;
	wire [31:0] wd, rdt;
	wire [3:0] ws;
	wire [1:0] br, rr;
	wire awv, awr, wv, wr_, bv, brd, arv, arr, rv, rrd;
	always #5 ref_clk = ~ref_clk;
	// Short timebase so comparator changes settle in a few cycles
	bsm_monitor #(.TICK_DIV(4)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .cmp_below_backup(bb),
		.cmp_above_backup(ab), .cmp_below_trip(bt), .cmp_above_trip_hys(at), .cmp_brownout(brn),
		.cmp_batt_below85(b85), .cmp_batt_below75(b75), .total_loss_seen(tls), .cur_time(cur_time),
		.backup_mode(bm), .serial_if_enable(sie), .temp_sense_run(tsr), .batt_measure(bms),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rrd));
	bsm_host_model i_host (.ref_clk(ref_clk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd), .wstrb(ws),
		.wvalid(wv), .wready(wr_), .bresp(br), .bvalid(bv), .bready(brd), .araddr(ara), .arvalid(arv),
		.arready(arr), .rdata(rdt), .rresp(rr), .rvalid(rv), .rready(rrd));
	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t ns: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic settle();
		repeat (16) @(posedge ref_clk);
	endtask
	task automatic peek(input logic [7:0] a);
		i_host.rd(a, d, r);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// One loss of main supply and its return, return cause chosen by via_trip
	task automatic cycle_power(input logic [31:0] t_in, input logic [31:0] t_out, input logic backup_temp_sense_enable, input logic via_trip);
		i_host.wr(BSM_CTRL_OFS, (32'h1 << BSM_TSE_BIT) | (32'(backup_temp_sense_enable) << BSM_BACKUP_TEMP_SENSE_ENABLE_BIT), r);
		cur_time <= t_in;
		bb <= 1'b1;
		settle();
		chk(bm, 1'b0);
		bt <= 1'b1;
		settle();
		chk(bm, 1'b1);
		chk(sie, 1'b0);
		chk(tsr, backup_temp_sense_enable);
		peek(BSM_TIME_OFS);
		chk(r, BSM_RESP_SLVERR);
		chk(d, 32'h0);
		i_host.wr(BSM_CTRL_OFS, 32'h1 << BSM_CLR_BIT, r);
		chk(r, BSM_RESP_SLVERR);
		b85 <= 1'b0;
		b75 <= 1'b0;
		cur_time <= t_out;
		{bb, bt, ab, at} <= {2'b00, !via_trip, via_trip};
		settle();
		chk(bm, 1'b0);
		chk(sie, 1'b1);
		{ab, at} <= 2'b00;
	endtask
	// Cut a hang short well past the expected run length
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		{bb, ab, bt, at, b85, b75, brn} <= '0;
		tls <= 1'b1;
		cur_time <= 32'h0;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		settle();
		chk(sie, 1'b1);
		peek(BSM_STATUS_OFS);
		chk(d[BSM_ST_TPF], 1'b1);
		peek(8'h40);
		chk(r, BSM_RESP_SLVERR);
		chk(d, 32'h0);
		// Each trip level watches its own comparator only
		for (int k = 0; k < 6; k++)
		begin
			i_host.wr(BSM_CTRL_OFS, 32'(k) << BSM_TRIP_LSB, r);
			brn <= ~(6'h01 << k);
			settle();
			peek(BSM_STATUS_OFS);
			chk(d[BSM_ST_BRN], 1'b0);
			brn <= 6'h01 << k;
			settle();
			peek(BSM_STATUS_OFS);
			chk(d[BSM_ST_BRN], 1'b1);
			chk(sie, 1'b1);
		end
		// Out-of-range level code clamps; a low battery alone leaves LB1 clear until a measurement
		i_host.wr(BSM_CTRL_OFS, 32'h7 << BSM_TRIP_LSB, r);
		chk(r, BSM_RESP_OKAY);
		peek(BSM_CTRL_OFS);
		chk(d[BSM_TRIP_LSB +: BSM_TRIP_W], BSM_TRIP_MAX);
		brn <= 6'h00;
		b85 <= 1'b1;
		settle();
		peek(BSM_STATUS_OFS);
		chk(d[BSM_ST_LB1], 1'b0);
		// Battery flags follow a measurement started by the host
		for (int k = 0; k < 2; k++)
		begin
			b75 <= k[0];
			i_host.wr(BSM_CTRL_OFS, 32'h1 << BSM_TSE_BIT, r);
			settle();
			peek(BSM_STATUS_OFS);
			chk(d[BSM_ST_LB1], 1'b1);
			chk(d[BSM_ST_LB2], k[0]);
		end
		cycle_power(32'h0000_1111, 32'h0000_2222, 1'b0, 1'b0);
		peek(BSM_STATUS_OFS);
		chk(d[BSM_ST_LB2], 1'b1);
		peek(BSM_V2B_OFS);
		chk(d, 32'h0000_1111);
		peek(BSM_B2V_OFS);
		chk(d, 32'h0000_2222);
		cycle_power(32'h0000_3333, 32'h0000_4444, 1'b1, 1'b1);
		peek(BSM_V2B_OFS);
		chk(d, 32'h0000_1111);
		peek(BSM_B2V_OFS);
		chk(d, 32'h0000_4444);
		i_host.wr(BSM_CTRL_OFS, 32'h1 << BSM_CLR_BIT, r);
		peek(BSM_V2B_OFS);
		chk(d, 32'h0);
		tally_and_finish();
	end
endmodule // test_battery_switchover_monitor
